/* File: design/pss_pkg.sv */
package pss_pkg;

  // Clock and time base
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          US_PER_S        = 1_000_000;
  localparam int          MS_PER_S        = 1_000;
  localparam int          TICK_CYCLES     = CLK_HZ / US_PER_S;
  localparam logic [3:0]  TICK_LAST       = 4'(TICK_CYCLES - 1);
  localparam int          HOLD_TIME_MS    = 1000;
  localparam int          HOLD_CYCLES_DEF = HOLD_TIME_MS * (CLK_HZ / MS_PER_S);

  // Register byte offsets
  localparam logic [5:0]  REG_CTRL        = 6'h00;
  localparam logic [5:0]  REG_BEGIN       = 6'h04;
  localparam logic [5:0]  REG_END         = 6'h08;
  localparam logic [5:0]  REG_SCAN_TIME   = 6'h0c;
  localparam logic [5:0]  REG_UPDATE      = 6'h10;
  localparam logic [5:0]  REG_RATIO_UP    = 6'h14;
  localparam logic [5:0]  REG_RATIO_DN    = 6'h18;
  localparam logic [5:0]  REG_STATUS      = 6'h1c;
  localparam logic [5:0]  REG_IRQ_STATUS  = 6'h20;
  localparam logic [5:0]  REG_IRQ_MASK    = 6'h24;
  localparam logic [5:0]  REG_VALUE       = 6'h28;

  // Control field positions
  localparam int          CTRL_TGT_LSB    = 0;
  localparam int          CTRL_LOG_BIT    = 4;
  localparam int          CTRL_MODE_LSB   = 8;

  // Status field positions
  localparam int          STAT_READY_BIT  = 4;
  localparam int          STAT_RUN_BIT    = 5;
  localparam int          STAT_PAUSE_BIT  = 6;
  localparam int          STAT_DONE_BIT   = 7;
  localparam int          STAT_DOWN_BIT   = 8;
  localparam int          STAT_IDX_LSB    = 16;

  // Values after reset
  localparam logic [31:0] RST_SCAN_TIME   = 32'h000f4240;
  localparam logic [31:0] RST_UPDATE      = 32'h000003e8;
  localparam logic [31:0] RST_RATIO       = 32'h00010000;
  localparam logic [31:0] RST_VALUE       = 32'h00000000;
  localparam int          RATIO_FRAC      = 16;

  // Interrupt bit positions
  localparam int          IRQ_READY       = 0;
  localparam int          IRQ_RUN         = 1;
  localparam int          IRQ_PAUSE       = 2;
  localparam int          IRQ_PASS        = 3;
  localparam int          IRQ_DONE        = 4;
  localparam int          IRQ_OFF         = 5;
  localparam int          IRQ_W           = 6;

  // Keys and divider
  localparam int          KEY_SCAN        = 0;
  localparam int          KEY_PLAY        = 1;
  localparam logic [5:0]  DIV_LAST        = 6'h1f;

  typedef enum logic [2:0] {
    TGT_FREQ = 3'h0,
    TGT_AMP  = 3'h1,
    TGT_DC   = 3'h2,
    TGT_AUX1 = 3'h3,
    TGT_AUX2 = 3'h4
  } pss_target_type;

  typedef enum logic [1:0] {
    MODE_REPEAT = 2'h0,
    MODE_UPDOWN = 2'h1,
    MODE_ONCE   = 2'h2
  } pss_mode_type;

  typedef enum logic [2:0] {
    ST_OFF   = 3'h0,
    ST_LOAD  = 3'h1,
    ST_READY = 3'h3,
    ST_RUN   = 3'h2,
    ST_DONE  = 3'h6,
    ST_PAUSE = 3'h7
  } pss_state_type;

endpackage

/* File: design/pss_parameter_scan_sequencer.sv */
`timescale 1ns/100ps

// What this block does
// (RULE1) Target chosen among frequency, amplitude, DC level, aux out one or two.
// (RULE2) Spacing is linear increments or logarithmic progression, set by configuration.
// (RULE3) Sweep starts at begin value and finishes at end value.
// (RULE4) Scan time is the whole travel time from begin to end.
// (RULE5) Each step is held one update interval; steps equal time over interval.
// (RULE6) End modes: repeat, up/down, or single pass then stop.
// (RULE7) Repeat and up/down keep cycling with no stop.
// (RULE8) Single pass stops at end, requests chart pause, lights done.
// (RULE9) Brief scan key toggles scanning; enabling sets begin value and ready.
// (RULE10) Brief play while ready starts the sweep and lights run.
// (RULE11) While running, brief play alternates pause and resume; pause lamp shows it.
// (RULE12) Holding play returns to begin, keeps ready, clears done.
// (RULE13) Play key ignored unless scanning is on and ready is lit.
// (RULE14) Disabling restores the value from before scanning and frees panel control.
// (RULE15) Configuration latched on enable; edits act after re-enable or play hold. Target edits act only after re-enable; play hold keeps the old target.
// (RULE16) Up/down reverses direction at each range end.
// (RULE17) Log steps differ by a constant ratio; final step lands on end value.
module pss_parameter_scan_sequencer #(
  parameter int HOLD_CYCLES = pss_pkg::HOLD_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // Avalon-MM register slave
  input  wire logic [5:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // Interrupt
  output logic                         irq,
  // Front panel keys, pressed high, asynchronous
  input  wire logic                    scanKeyPin,
  input  wire logic                    playKeyPin,
  // Panel value of the selected target
  input  wire logic [31:0]             panelValue,
  // Swept parameter
  output pss_pkg::pss_target_type      paramTarget,
  output logic      [31:0]             paramValue,
  output logic                         paramOwn,
  output logic                         paramUpdate,
  // Indicators
  output logic                         readyLed,
  output logic                         runLed,
  output logic                         pauseLed,
  output logic                         doneLed,
  output logic                         chartPause
);
  import pss_pkg::*;

  localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);

  typedef struct packed {
    pss_state_type       state;
    logic [1:0]          sync1;
    logic [1:0]          sync2;
    logic [1:0][31:0]    holdCnt;
    logic [1:0]          held;
    pss_target_type      cfgTarget;
    logic                cfgLog;
    pss_mode_type        cfgMode;
    logic [31:0]         cfgBegin;
    logic [31:0]         cfgEnd;
    logic [31:0]         cfgTime;
    logic [31:0]         cfgUpdate;
    logic [31:0]         cfgRatioUp;
    logic [31:0]         cfgRatioDn;
    pss_target_type      lTarget;
    logic                lLog;
    pss_mode_type        lMode;
    logic [31:0]         lBegin;
    logic [31:0]         lEnd;
    logic [31:0]         lUpdate;
    logic [31:0]         lRatioUp;
    logic [31:0]         lRatioDn;
    logic [31:0]         steps;
    logic [31:0]         delta;
    logic                deltaNeg;
    logic [31:0]         stepIdx;
    logic                down;
    logic [3:0]          tickCnt;
    logic [31:0]         usCnt;
    logic [31:0]         savedValue;
    logic [31:0]         value;
    logic                own;
    logic                update;
    logic [31:0]         divNum;
    logic [31:0]         divDen;
    logic [31:0]         divQ;
    logic [31:0]         divRem;
    logic [5:0]          divCnt;
    logic                divPhase;
    logic [IRQ_W-1:0]    irqStatus;
    logic [IRQ_W-1:0]    irqMask;
    logic                ack;
    logic [31:0]         readData;
  } pss_regs_type;

  pss_regs_type s;
  pss_regs_type next_s;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] pss_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Handshake answers one cycle after the request appears
  assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
  assign avs_readdata    = s.readData;
  assign irq             = |(s.irqStatus & s.irqMask);
  assign paramTarget     = s.lTarget;
  assign paramValue      = s.value;
  assign paramOwn        = s.own;
  assign paramUpdate     = s.update;
  assign readyLed        = (s.state != ST_OFF);
  assign runLed          = (s.state == ST_RUN);
  assign pauseLed        = (s.state == ST_PAUSE);
  assign doneLed         = (s.state == ST_DONE);
  assign chartPause      = (s.state == ST_DONE);

  // Next-state logic for the whole block
  always_comb begin
    logic [1:0]        brief;
    logic [1:0]        hold;
    logic [IRQ_W-1:0]  ev;
    logic              req;
    logic              done;
    logic              irqClr;
    logic [31:0]       rd;
    logic [31:0]       wv;
    logic              goOff;
    logic              load;
    logic              stepNow;
    logic [31:0]       remShift;
    logic              qBit;
    logic [31:0]       diff;
    logic [63:0]       prod;
    brief    = 2'h0;
    hold     = 2'h0;
    ev       = '0;
    req      = avs_read | avs_write;
    done     = req & s.ack;
    irqClr   = 1'b0;
    rd       = 32'h00000000;
    wv       = pss_merge(32'h00000000, avs_writedata, avs_byteenable);
    goOff    = 1'b0;
    load     = 1'b0;
    stepNow  = 1'b0;
    remShift = 32'h00000000;
    qBit     = 1'b0;
    diff     = 32'h00000000;
    prod     = 64'h0000000000000000;
    next_s   = s;
    next_s.update = 1'b0;

    // Key synchronisers; first stage feeds only the second
    next_s.sync1 = {playKeyPin, scanKeyPin};
    next_s.sync2 = s.sync1;

    // Brief press on release, hold once the count expires
    for (int k = 0; k < 2; k++) begin
      if (s.sync2[k]) begin
        if (!s.held[k]) begin
          if (s.holdCnt[k] == HOLD_LAST) begin
            next_s.held[k] = 1'b1;
            hold[k] = 1'b1;
          end else begin
            next_s.holdCnt[k] = s.holdCnt[k] + 32'h00000001;
          end
        end
      end else begin
        brief[k] = (s.holdCnt[k] != 32'h00000000) && !s.held[k];
        next_s.holdCnt[k] = 32'h00000000;
        next_s.held[k] = 1'b0;
      end
    end

    // Bus: register the read word in the waiting cycle
    next_s.ack = req & ~s.ack;
    if (req && !s.ack) begin
      unique case (avs_address)
        REG_CTRL: begin
          rd[CTRL_TGT_LSB +: 3]  = s.cfgTarget;
          rd[CTRL_LOG_BIT]       = s.cfgLog;
          rd[CTRL_MODE_LSB +: 2] = s.cfgMode;
        end
        REG_BEGIN:      rd = s.cfgBegin;
        REG_END:        rd = s.cfgEnd;
        REG_SCAN_TIME:  rd = s.cfgTime;
        REG_UPDATE:     rd = s.cfgUpdate;
        REG_RATIO_UP:   rd = s.cfgRatioUp;
        REG_RATIO_DN:   rd = s.cfgRatioDn;
        REG_STATUS: begin
          rd[2:0]                 = s.state;
          rd[STAT_READY_BIT]      = readyLed;
          rd[STAT_RUN_BIT]        = runLed;
          rd[STAT_PAUSE_BIT]      = pauseLed;
          rd[STAT_DONE_BIT]       = doneLed;
          rd[STAT_DOWN_BIT]       = s.down;
          rd[STAT_IDX_LSB +: 16]  = s.stepIdx[15:0];
        end
        REG_IRQ_STATUS: rd[IRQ_W-1:0] = s.irqStatus;
        REG_IRQ_MASK:   rd[IRQ_W-1:0] = s.irqMask;
        REG_VALUE:      rd = s.value;
        default:        rd = 32'h00000000;
      endcase
      next_s.readData = rd;
    end

    // Bus: writes and read-clear take effect at the completing edge
    if (done && avs_write) begin
      unique case (avs_address)
        REG_CTRL: begin
          wv = pss_merge({22'h000000, s.cfgMode, 3'h0, s.cfgLog, 1'b0, s.cfgTarget},
                         avs_writedata, avs_byteenable);
          // Codes beyond the last target fall back to frequency
          next_s.cfgTarget = (wv[CTRL_TGT_LSB +: 3] > TGT_AUX2) ? TGT_FREQ
                           : pss_target_type'(wv[CTRL_TGT_LSB +: 3]); // [RULE1]
          next_s.cfgLog    = wv[CTRL_LOG_BIT]; // [RULE2]
          next_s.cfgMode   = (wv[CTRL_MODE_LSB +: 2] == 2'h3) ? MODE_ONCE
                           : pss_mode_type'(wv[CTRL_MODE_LSB +: 2]); // [RULE6]
        end
        REG_BEGIN:     next_s.cfgBegin   = pss_merge(s.cfgBegin, avs_writedata, avs_byteenable);
        REG_END:       next_s.cfgEnd     = pss_merge(s.cfgEnd, avs_writedata, avs_byteenable);
        REG_SCAN_TIME: next_s.cfgTime    = pss_merge(s.cfgTime, avs_writedata, avs_byteenable);
        REG_UPDATE:    next_s.cfgUpdate  = pss_merge(s.cfgUpdate, avs_writedata, avs_byteenable);
        REG_RATIO_UP:  next_s.cfgRatioUp = pss_merge(s.cfgRatioUp, avs_writedata,
                                                     avs_byteenable);
        REG_RATIO_DN:  next_s.cfgRatioDn = pss_merge(s.cfgRatioDn, avs_writedata,
                                                     avs_byteenable);
        REG_IRQ_MASK:  next_s.irqMask    = wv[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    irqClr = done && avs_read && (avs_address == REG_IRQ_STATUS);

    // Scan state machine; scan key is honoured in every state
    unique case (s.state)
      ST_OFF: begin
        if (brief[KEY_SCAN]) begin
          next_s.savedValue = panelValue; // [RULE14]
          next_s.lTarget    = s.cfgTarget; // [RULE1]
          load = 1'b1; // [RULE9]
        end
      end
      ST_LOAD: begin
        if (brief[KEY_SCAN]) begin
          goOff = 1'b1;
        end else begin
          // One restoring division bit per cycle
          remShift = {s.divRem[30:0], s.divNum[31]};
          qBit = (remShift >= s.divDen);
          next_s.divRem = qBit ? (remShift - s.divDen) : remShift;
          next_s.divNum = {s.divNum[30:0], 1'b0};
          next_s.divQ   = {s.divQ[30:0], qBit};
          next_s.divCnt = s.divCnt + 6'h01;
          if (s.divCnt == DIV_LAST) begin
            if (!s.divPhase) begin
              // Steps = scan time / update interval, at least one
              next_s.steps = (next_s.divQ == 32'h00000000) ? 32'h00000001
                                                          : next_s.divQ; // [RULE4] [RULE5]
              diff = s.lEnd - s.lBegin;
              next_s.deltaNeg = diff[31];
              next_s.divNum   = diff[31] ? (32'h00000000 - diff) : diff;
              next_s.divDen   = next_s.steps;
              next_s.divQ     = 32'h00000000;
              next_s.divRem   = 32'h00000000;
              next_s.divCnt   = 6'h00;
              next_s.divPhase = 1'b1;
            end else begin
              next_s.delta = next_s.divQ; // [RULE2]
              next_s.state = ST_READY;
              ev[IRQ_READY] = 1'b1;
            end
          end
        end
      end
      ST_READY: begin
        if (brief[KEY_SCAN]) begin
          goOff = 1'b1;
        end else if (hold[KEY_PLAY]) begin
          load = 1'b1; // [RULE12]
        end else if (brief[KEY_PLAY]) begin
          next_s.state = ST_RUN; // [RULE10]
          ev[IRQ_RUN] = 1'b1;
        end
      end
      ST_RUN: begin
        if (brief[KEY_SCAN]) begin
          goOff = 1'b1;
        end else if (hold[KEY_PLAY]) begin
          load = 1'b1; // [RULE12]
        end else if (brief[KEY_PLAY]) begin
          next_s.state = ST_PAUSE; // [RULE11]
          ev[IRQ_PAUSE] = 1'b1;
        end else begin
          // Microsecond tick, then the update interval
          if (s.tickCnt == TICK_LAST) begin
            next_s.tickCnt = 4'h0;
            if (s.usCnt >= s.lUpdate - 32'h00000001) begin
              next_s.usCnt = 32'h00000000;
              stepNow = 1'b1; // [RULE5]
            end else begin
              next_s.usCnt = s.usCnt + 32'h00000001;
            end
          end else begin
            next_s.tickCnt = s.tickCnt + 4'h1;
          end
        end
      end
      ST_PAUSE: begin
        // Timers freeze while paused
        if (brief[KEY_SCAN]) begin
          goOff = 1'b1;
        end else if (hold[KEY_PLAY]) begin
          load = 1'b1; // [RULE12]
        end else if (brief[KEY_PLAY]) begin
          next_s.state = ST_RUN; // [RULE11]
          ev[IRQ_RUN] = 1'b1;
        end
      end
      ST_DONE: begin
        // Brief play does nothing here; a hold re-arms the scan
        if (brief[KEY_SCAN]) begin
          goOff = 1'b1;
        end else if (hold[KEY_PLAY]) begin
          load = 1'b1; // [RULE12]
        end
      end
      default: begin
        next_s.state = ST_OFF;
      end
    endcase
    // Play key is only seen in states with ready lit and no load pending [RULE13]

    // One step of the sweep
    if (stepNow) begin
      next_s.update = 1'b1;
      if (s.stepIdx == s.steps) begin
        // Repeat restart after dwelling at the end value
        next_s.value   = s.lBegin; // [RULE7]
        next_s.stepIdx = 32'h00000000;
      end else if (s.stepIdx + 32'h00000001 == s.steps) begin
        next_s.value = s.down ? s.lBegin : s.lEnd; // [RULE3] [RULE17]
        ev[IRQ_PASS] = 1'b1;
        unique case (s.lMode)
          MODE_ONCE: begin
            next_s.state = ST_DONE; // [RULE8]
            ev[IRQ_DONE] = 1'b1;
          end
          MODE_UPDOWN: begin
            next_s.down    = ~s.down; // [RULE16]
            next_s.stepIdx = 32'h00000000; // [RULE7]
          end
          MODE_REPEAT: begin
            next_s.stepIdx = s.steps; // [RULE7]
          end
        endcase
      end else begin
        next_s.stepIdx = s.stepIdx + 32'h00000001;
        if (s.lLog) begin
          // Constant ratio per step, fixed point
          prod = 64'(s.value) * 64'(s.down ? s.lRatioDn : s.lRatioUp); // [RULE17]
          next_s.value = prod[RATIO_FRAC +: 32];
        end else if (s.deltaNeg ^ s.down) begin
          next_s.value = s.value - s.delta; // [RULE2]
        end else begin
          next_s.value = s.value + s.delta; // [RULE2]
        end
      end
    end

    // Latch configuration other than the target and start the step division
    if (load) begin
      next_s.lLog     = s.cfgLog; // [RULE15]
      next_s.lMode    = s.cfgMode;
      next_s.lBegin   = s.cfgBegin;
      next_s.lEnd     = s.cfgEnd;
      next_s.lRatioUp = s.cfgRatioUp;
      next_s.lRatioDn = s.cfgRatioDn;
      next_s.lUpdate  = (s.cfgUpdate == 32'h00000000) ? 32'h00000001 : s.cfgUpdate;
      next_s.divNum   = s.cfgTime;
      next_s.divDen   = next_s.lUpdate;
      next_s.divQ     = 32'h00000000;
      next_s.divRem   = 32'h00000000;
      next_s.divCnt   = 6'h00;
      next_s.divPhase = 1'b0;
      next_s.value    = s.cfgBegin; // [RULE9] [RULE3]
      next_s.own      = 1'b1;
      next_s.update   = 1'b1;
      next_s.down     = 1'b0;
      next_s.stepIdx  = 32'h00000000;
      next_s.tickCnt  = 4'h0;
      next_s.usCnt    = 32'h00000000;
      next_s.state    = ST_LOAD;
    end

    // Disable: give the old value back to the panel
    if (goOff) begin
      next_s.value  = s.savedValue; // [RULE14]
      next_s.own    = 1'b0;
      next_s.update = 1'b1;
      next_s.state  = ST_OFF;
      ev[IRQ_OFF]   = 1'b1;
    end

    // Sticky events; a new event beats a read-clear
    next_s.irqStatus = (irqClr ? '0 : s.irqStatus) | ev;
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s            <= '0;
      s.state      <= ST_OFF;
      s.cfgTarget  <= TGT_FREQ;
      s.cfgMode    <= MODE_REPEAT;
      s.lTarget    <= TGT_FREQ;
      s.lMode      <= MODE_REPEAT;
      s.cfgTime    <= RST_SCAN_TIME;
      s.cfgUpdate  <= RST_UPDATE;
      s.cfgRatioUp <= RST_RATIO;
      s.cfgRatioDn <= RST_RATIO;
      s.lUpdate    <= RST_UPDATE;
      s.steps      <= 32'h00000001;
      s.divDen     <= 32'h00000001;
      s.value      <= RST_VALUE;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* File: test/pss_checker.sv */
`timescale 1ns/100ps

module pss_checker
  import pss_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Register bus handshake
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // Swept parameter and indicators
  input wire logic [31:0] paramValue,
  input wire logic        paramOwn,
  input wire logic        paramUpdate,
  input wire logic        readyLed,
  input wire logic        runLed,
  input wire logic        pauseLed,
  input wire logic        doneLed,
  input wire logic        chartPause
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // Bus answers after exactly one wait state
  a_bus_wait_first: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read not stalled in its first cycle");
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access longer than one wait state");
  // Lamps follow the scan state
  a_done_chart: assert property (doneLed == chartPause)
    else $error("done lamp and chart pause disagree");
  a_play_gated: assert property (!readyLed |-> !(runLed || pauseLed || doneLed))
    else $error("scan lamps lit while scanning is off");
  a_own_ready: assert property (paramOwn == readyLed)
    else $error("target ownership differs from ready lamp");
  // Value frozen while paused or done
  a_pause_holds: assert property (pauseLed ##1 pauseLed |-> $stable(paramValue) && !runLed)
    else $error("value moved while paused");
  a_done_holds: assert property (doneLed ##1 doneLed |-> $stable(paramValue))
    else $error("value moved after the single pass ended");
  // Every value change is announced, steps are spaced by the dwell
  a_value_update: assert property (!$stable(paramValue) |-> paramUpdate)
    else $error("value changed without an update pulse");
  a_step_dwell: assert property (paramUpdate && runLed |=> (!paramUpdate || !runLed) [*8])
    else $error("steps closer than one dwell");
  a_enable_load: assert property ($rose(readyLed) |-> paramUpdate)
    else $error("enable did not load the begin value");
  a_off_restore: assert property ($fell(paramOwn) |-> paramUpdate)
    else $error("disable did not restore the value");
endmodule

bind pss_parameter_scan_sequencer pss_checker chk (
  .clock, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .paramValue, .paramOwn,
  .paramUpdate, .readyLed, .runLed, .pauseLed, .doneLed, .chartPause
);

/* File: test/pss_panel_model.sv */
`timescale 1ns/100ps

module pss_panel_model (
  // Clock and swept output
  input  wire logic        clock,
  input  wire logic        paramUpdate,
  input  wire logic [31:0] paramValue,
  // Keys and panel value
  output logic             scanKeyPin,
  output logic             playKeyPin,
  output logic      [31:0] panelValue
);
  logic [31:0] seen[$];

  // Keys idle, panel holds a fixed setting
  initial begin
    scanKeyPin = 1'b0;
    playKeyPin = 1'b0;
    panelValue = 32'h00000077;
  end

  // Log each value the sequencer applies
  always @(posedge clock)
    if (paramUpdate === 1'b1)
      seen.push_back(paramValue);

  // Clean press; settles so the next press is never merged with it
  task automatic press(input int key, input int cycles);
    @(posedge clock);
    if (key == 0)
      scanKeyPin <= 1'b1;
    else
      playKeyPin <= 1'b1;
    repeat (cycles) @(posedge clock);
    scanKeyPin <= 1'b0;
    playKeyPin <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
endmodule

/* File: test/pss_parameter_scan_sequencer_test.sv */
`timescale 1ns/100ps

module pss_parameter_scan_sequencer_test;
  import pss_pkg::*;
  logic           clock, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic           scanKeyPin, playKeyPin, paramOwn, paramUpdate;
  logic           readyLed, runLed, pauseLed, doneLed, chartPause;
  logic [5:0]     avs_address;
  logic [31:0]    avs_writedata, avs_readdata, panelValue, paramValue, q;
  pss_target_type paramTarget;
  int             numErrors = 0, nTests = 0, cyc = 0, n = 0;
  logic [31:0]    linExp[4] = '{32'h000000c8, 32'h0000012c, 32'h00000190, 32'h000001f4};
  logic [31:0]    logExp[8] = '{32'h20, 32'h40, 32'h80, 32'h100, 32'h80, 32'h40, 32'h20, 32'h10};

  pss_parameter_scan_sequencer #(.HOLD_CYCLES(20)) uut (
    .clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .irq, .scanKeyPin,
    .playKeyPin, .panelValue, .paramTarget, .paramValue, .paramOwn, .paramUpdate,
    .readyLed, .runLed, .pauseLed, .doneLed, .chartPause
  );
  pss_panel_model pm (.clock, .paramUpdate, .paramValue, .scanKeyPin, .playKeyPin, .panelValue);

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      numErrors++;
      wrapUp();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock iff avs_waitrequest === 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic waitSeen(input int cnt);
    for (int i = 0; i < 500 && pm.seen.size() < cnt; i++) @(posedge clock);
  endtask

  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    bus(0, REG_SCAN_TIME, 0);
    chk("scan_time", RST_SCAN_TIME, q);
    bus(0, REG_RATIO_UP, 0);
    chk("ratio_up", RST_RATIO, q);
    bus(0, 6'h3c, 0);
    chk("unmapped", 32'h0, q);
    bus(1, REG_VALUE, 32'h5);
    bus(0, REG_VALUE, 0);
    chk("value_ro", RST_VALUE, q);
    // Single linear pass on aux one, 4 steps of 1 us
    bus(1, REG_CTRL, 32'h00000203);
    bus(1, REG_BEGIN, 32'h64);
    bus(1, REG_END, 32'h1f4);
    bus(1, REG_SCAN_TIME, 32'h4);
    bus(1, REG_UPDATE, 32'h1);
    bus(1, REG_IRQ_MASK, 32'h1);
    pm.press(0, 3);
    repeat (70) @(posedge clock);
    chk("begin", 32'h64, paramValue);
    chk("target", 32'(TGT_AUX1), 32'(paramTarget));
    bus(0, REG_STATUS, 0);
    chk("state", 32'(ST_READY), {29'h0, q[2:0]});
    chk("irq_set", 1, irq);
    bus(0, REG_IRQ_STATUS, 0);
    chk("irq_ready", 1, q[IRQ_READY]);
    // The clear lands at the completing edge, so look once it has settled
    @(negedge clock);
    chk("irq_clr", 0, irq);
    pm.seen.delete();
    pm.press(1, 3);
    chk("run", 1, runLed);
    waitSeen(4);
    repeat (4) @(posedge clock);
    foreach (linExp[i]) chk("lin_step", linExp[i], pm.seen[i]);
    chk("done", 1, doneLed);
    chk("chart", 1, chartPause);
    // Edits while latched do not disturb the finished pass
    bus(1, REG_CTRL, 32'h00000112);
    bus(1, REG_BEGIN, 32'h10);
    bus(1, REG_END, 32'h100);
    bus(1, REG_RATIO_UP, 32'h00020000);
    bus(1, REG_RATIO_DN, 32'h00008000);
    chk("latched", 32'h1f4, paramValue);
    pm.press(1, 25);
    chk("hold_ready", 1, readyLed);
    chk("hold_done", 0, doneLed);
    chk("relatch", 32'h10, paramValue);
    // Logarithmic up/down run with a pause in the middle; play is ignored until ready
    repeat (60) @(posedge clock);
    pm.seen.delete();
    pm.press(1, 3);
    waitSeen(2);
    pm.press(1, 3);
    chk("pause", 1, pauseLed);
    n = pm.seen.size();
    repeat (40) @(posedge clock);
    chk("frozen", n, pm.seen.size());
    pm.press(1, 3);
    chk("resume", 1, runLed);
    waitSeen(8);
    foreach (logExp[i]) chk("log_step", logExp[i], pm.seen[i]);
    chk("cycling", 1, runLed);
    pm.press(0, 3);
    chk("restore", 32'h77, paramValue);
    chk("own_off", 0, paramOwn);
    pm.press(1, 3);
    chk("play_off", 0, runLed);
    wrapUp();
  end
endmodule
